// file: hdl/bb_data_source.sv
module bb_data_source #(
    parameter int BIT_DIV = bbsrc_pkg::BIT_DIV_RST
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire bbsrc_pkg::reg_req_t  req_in,
    output logic [31:0]               rdata_out,
    input  wire logic                 trig_in,
    input  wire logic                 data_in,
    input  wire logic [1:0]           alt_in,
    output logic [1:0]                sym_out,
    output logic                      sym_valid_out,
    output logic [3:0]                marker_a_out,
    output logic [3:0]                marker_b_out,
    output logic [3:0]                conn_out,
    output logic                      clk_out_en_out,
    output logic                      clk_ext_sel_out
);

    ////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        bbsrc_pkg::ctrl_t     ctrl;
        bbsrc_pkg::src_t      src;
        bbsrc_pkg::prbs_len_t plen;
        bbsrc_pkg::src_t      src_pend;
        bbsrc_pkg::prbs_len_t plen_pend;
        logic                 pend;
        logic [63:0]          pat;
        logic [5:0]           patlen;
        logic [15:0]          strm_len;
        logic [10:0]          saddr;
        bbsrc_pkg::mkr_cfg_t [3:0] mcfg;
        bbsrc_pkg::mkr_st_t  [3:0] mst;
        logic [3:0]           lvl;
        logic [3:0]           route;
        logic                 map1;
        logic                 map3;
        logic [22:0]          lfsr;
        logic [5:0]           pidx;
        logic [15:0]          sptr;
        logic [7:0]           div_cnt;
        logic                 bit_cnt;
        logic                 sym_sh;
        logic [1:0]           sym;
        logic                 sym_vld;
        logic [2:0]           trig_sync;
        logic                 trig_f;
        logic [2:0]           data_sync;
        logic                 data_f;
        logic                 run_d;
        logic [31:0]          rdata;
    } state_t;

    state_t      s_reg;
    state_t      s_next;
    logic [31:0] mem_rdata;
    logic        mem_we;

    localparam logic [7:0] BIT_LAST = 8'(BIT_DIV - 1);

    // All-ones seed of the selected length: never the locked zero state.
    function automatic logic [22:0] seed_of(bbsrc_pkg::prbs_len_t l);
        logic [4:0] n;
        n = bbsrc_pkg::PRBS_LEN[l];
        seed_of = bbsrc_pkg::PRBS_ONES >> (5'd23 - n);
    endfunction : seed_of

    // One step of the selected generator; stage 0 is the output.
    function automatic logic [22:0] prbs_step(logic [22:0] v,
                                              bbsrc_pkg::prbs_len_t l);
        logic [22:0] t;
        logic        fb;
        fb = ^(v & bbsrc_pkg::PRBS_TAPS[l]);
        t = v >> 1;
        t[bbsrc_pkg::PRBS_LEN[l] - 5'd1] = fb;
        prbs_step = t;
    endfunction : prbs_step

    ////////////////////////////////////////////////////////////////////////
    // Stored list memory; its read port lags the pointer by one cycle,
    // which is why a bit takes at least two clocks.
    assign mem_we = req_in.wr && req_in.addr == bbsrc_pkg::STRM_DATA_OFS;

    stream_mem #(
        .WIDTH (32),
        .DEPTH (bbsrc_pkg::STRM_WORDS)
    ) u_mem (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (s_reg.saddr),
        .wr_data_in  (req_in.wdata),
        .rd_addr_in  (s_reg.sptr[15:5]),
        .rd_data_out (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        logic                 restart;
        logic                 tick;
        logic                 bitv;
        logic                 bound;
        logic [1:0]           m;
        logic [15:0]          lim;
        bbsrc_pkg::mkr_cfg_t  c;
        bbsrc_pkg::mkr_st_t   st;
        s_next  = s_reg;
        restart = 1'b0;
        tick    = 1'b0;
        bitv    = 1'b0;
        bound   = 1'b0;
        m       = 2'h0;
        lim     = 16'h0000;
        c       = '0;
        st      = '0;
        s_next.sym_vld = 1'b0;

        // Pin inputs: three flops, accepted once stages two and three agree.
        s_next.trig_sync = {s_reg.trig_sync[1:0], trig_in};
        s_next.data_sync = {s_reg.data_sync[1:0], data_in};
        if (s_reg.trig_sync[1] == s_reg.trig_sync[2]) begin
            s_next.trig_f = s_reg.trig_sync[2];
        end
        if (s_reg.data_sync[1] == s_reg.data_sync[2]) begin
            s_next.data_f = s_reg.data_sync[2];
        end

        // Register writes.
        if (req_in.wr) begin
            m = req_in.addr[5:4];
            if (req_in.addr[7:6] == bbsrc_pkg::MKR_BLOCK) begin
                unique case (req_in.addr[3:2])
                    bbsrc_pkg::MKR_CFG_IDX: begin
                        s_next.mcfg[m].mode =
                            bbsrc_pkg::mk_mode_t'(req_in.wdata[1:0]);
                        s_next.mcfg[m].plen = req_in.wdata[7:2];
                    end
                    bbsrc_pkg::MKR_CNT_IDX: begin
                        s_next.mcfg[m].on_len  = req_in.wdata[15:0];
                        s_next.mcfg[m].off_len = req_in.wdata[31:16];
                    end
                    bbsrc_pkg::MKR_PLO_IDX: begin
                        s_next.mcfg[m].pat[31:0] = req_in.wdata;
                    end
                    bbsrc_pkg::MKR_PHI_IDX: begin
                        s_next.mcfg[m].pat[63:32] = req_in.wdata;
                    end
                endcase
            end
            case (req_in.addr)
                bbsrc_pkg::CTRL_OFS: begin
                    s_next.ctrl = bbsrc_pkg::ctrl_t'(req_in.wdata[4:0]);
                end
                bbsrc_pkg::SRC_OFS: begin
                    s_next.src_pend =
                        bbsrc_pkg::src_t'(req_in.wdata[2:0]);
                    s_next.plen_pend = bbsrc_pkg::prbs_len_t'(
                        req_in.wdata[bbsrc_pkg::SRC_LEN_POS +: 3]);
                    s_next.pend = 1'b1;
                end
                bbsrc_pkg::PAT_LO_OFS: s_next.pat[31:0] = req_in.wdata;
                bbsrc_pkg::PAT_HI_OFS: s_next.pat[63:32] = req_in.wdata;
                bbsrc_pkg::PAT_LEN_OFS: s_next.patlen = req_in.wdata[5:0];
                bbsrc_pkg::STRM_LEN_OFS: begin
                    s_next.strm_len = req_in.wdata[15:0];
                end
                bbsrc_pkg::STRM_ADDR_OFS: s_next.saddr = req_in.wdata[10:0];
                bbsrc_pkg::STRM_DATA_OFS: s_next.saddr = s_reg.saddr + 11'h1;
                bbsrc_pkg::RESTART_OFS: begin
                    restart = !s_reg.ctrl.trig_ext;
                end
                bbsrc_pkg::MAP_OFS: begin
                    s_next.route = req_in.wdata[3:0];
                    s_next.map1  = req_in.wdata[bbsrc_pkg::MAP_CONN1_POS];
                    s_next.map3  = req_in.wdata[bbsrc_pkg::MAP_CONN3_POS];
                end
                default: ;
            endcase
        end

        // External trigger edge restarts generation like a software restart.
        if (s_reg.ctrl.trig_ext && s_next.trig_f && !s_reg.trig_f) begin
            restart = 1'b1;
        end
        s_next.run_d = s_reg.ctrl.run;
        if (s_reg.ctrl.run && !s_reg.run_d) begin
            restart = 1'b1;
        end

        // Serial bit generation.
        if (s_reg.ctrl.run) begin
            if (s_reg.div_cnt == BIT_LAST) begin
                tick = 1'b1;
                s_next.div_cnt = 8'h00;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 8'h01;
            end
        end
        if (s_reg.ctrl.data_ext) begin
            bitv = s_reg.data_f;
        end else begin
            case (s_reg.src)
                bbsrc_pkg::SRC_PRBS:    bitv = s_reg.lfsr[0];
                bbsrc_pkg::SRC_ZERO:    bitv = 1'b0;
                bbsrc_pkg::SRC_ONE:     bitv = 1'b1;
                bbsrc_pkg::SRC_PATTERN: bitv = s_reg.pat[s_reg.pidx];
                bbsrc_pkg::SRC_STREAM:  bitv = mem_rdata[s_reg.sptr[4:0]];
                default:                bitv = 1'b0;
            endcase
        end
        // A restart edge emits no symbol: its bit would belong to the old run.
        if (tick && !restart) begin
            s_next.lfsr = prbs_step(s_reg.lfsr, s_reg.plen);
            s_next.pidx = (s_reg.pidx == s_reg.patlen) ? 6'h00
                                                       : s_reg.pidx + 6'h01;
            s_next.sptr = (s_reg.sptr == s_reg.strm_len) ? 16'h0000
                                                        : s_reg.sptr + 16'h1;
            if (s_reg.ctrl.qpsk && !s_reg.bit_cnt) begin
                s_next.sym_sh  = bitv;
                s_next.bit_cnt = 1'b1;
            end else begin
                s_next.sym = s_reg.ctrl.qpsk ? {s_reg.sym_sh, bitv}
                                             : {1'b0, bitv};
                s_next.sym_vld = 1'b1;
                s_next.bit_cnt = 1'b0;
                bound = 1'b1;
            end
        end

        // Pending selection: at a symbol boundary, or at once when idle.
        if (s_reg.pend && (bound || !s_reg.ctrl.run || restart)) begin
            s_next.src  = s_reg.src_pend;
            s_next.plen = s_reg.plen_pend;
            s_next.pend = 1'b0;
            s_next.lfsr = seed_of(s_reg.plen_pend);
            s_next.pidx = 6'h00;
            s_next.sptr = 16'h0000;
        end

        // Markers advance once per symbol.
        for (int i = 0; i < bbsrc_pkg::NUM_MARKERS; i++) begin
            c = s_reg.mcfg[i];
            if (bound) begin
                s_next.mst[i].first = 1'b0;
                s_next.mst[i].idx = (s_reg.mst[i].idx == c.plen) ? 6'h00
                                    : s_reg.mst[i].idx + 6'h01;
                if (c.mode == bbsrc_pkg::MK_PULSE) begin
                    lim = c.on_len >> 1;
                end else begin
                    lim = s_reg.mst[i].ph ? c.on_len : c.off_len;
                end
                if (s_reg.mst[i].cnt + 16'h1 >= lim) begin
                    s_next.mst[i].cnt = 16'h0000;
                    s_next.mst[i].ph  = !s_reg.mst[i].ph;
                end else begin
                    s_next.mst[i].cnt = s_reg.mst[i].cnt + 16'h1;
                end
            end
        end

        // Restart: every generator and marker begins again from its start.
        if (restart) begin
            s_next.div_cnt = 8'h00;
            s_next.bit_cnt = 1'b0;
            s_next.pidx    = 6'h00;
            s_next.sptr    = 16'h0000;
            s_next.lfsr    = seed_of(s_next.plen);
            for (int i = 0; i < bbsrc_pkg::NUM_MARKERS; i++) begin
                s_next.mst[i] = '{cnt: 16'h0000, ph: 1'b1, first: 1'b1,
                                  idx: 6'h00};
            end
        end

        // Marker state counts symbols already sent, so the level beside a
        // symbol comes from the state before that symbol's advance. It is
        // loaded only at a boundary or a restart and forced low while run is off,
        // so it changes on the same edge as the symbol it marks and the first symbol gets step zero.
        for (int i = 0; i < bbsrc_pkg::NUM_MARKERS; i++) begin
            c  = s_next.mcfg[i];
            st = restart ? s_next.mst[i] : s_reg.mst[i];
            if (bound || restart) begin
                unique case (c.mode)
                    bbsrc_pkg::MK_RESTART: s_next.lvl[i] = st.first;
                    bbsrc_pkg::MK_PULSE:   s_next.lvl[i] = st.ph;
                    bbsrc_pkg::MK_RATIO:   s_next.lvl[i] = st.ph;
                    bbsrc_pkg::MK_PATTERN: begin
                        s_next.lvl[i] = c.pat[st.idx];
                    end
                endcase
            end
            s_next.lvl[i] = s_next.lvl[i] & s_next.ctrl.run;
        end

        // Register reads: data stand in the cycle after the strobe.
        s_next.rdata = 32'h0000_0000;
        if (req_in.rd) begin
            m = req_in.addr[5:4];
            if (req_in.addr[7:6] == bbsrc_pkg::MKR_BLOCK) begin
                unique case (req_in.addr[3:2])
                    bbsrc_pkg::MKR_CFG_IDX: begin
                        s_next.rdata = {24'h000000, s_reg.mcfg[m].plen,
                                        s_reg.mcfg[m].mode};
                    end
                    bbsrc_pkg::MKR_CNT_IDX: begin
                        s_next.rdata = {s_reg.mcfg[m].off_len,
                                        s_reg.mcfg[m].on_len};
                    end
                    bbsrc_pkg::MKR_PLO_IDX: begin
                        s_next.rdata = s_reg.mcfg[m].pat[31:0];
                    end
                    bbsrc_pkg::MKR_PHI_IDX: begin
                        s_next.rdata = s_reg.mcfg[m].pat[63:32];
                    end
                endcase
            end
            case (req_in.addr)
                bbsrc_pkg::CTRL_OFS: s_next.rdata = {27'h0, s_reg.ctrl};
                bbsrc_pkg::SRC_OFS: begin
                    s_next.rdata = {25'h0, s_reg.plen_pend, 1'b0,
                                    s_reg.src_pend};
                end
                bbsrc_pkg::PAT_LO_OFS:  s_next.rdata = s_reg.pat[31:0];
                bbsrc_pkg::PAT_HI_OFS:  s_next.rdata = s_reg.pat[63:32];
                bbsrc_pkg::PAT_LEN_OFS: s_next.rdata = {26'h0, s_reg.patlen};
                bbsrc_pkg::STRM_LEN_OFS: begin
                    s_next.rdata = {16'h0000, s_reg.strm_len};
                end
                bbsrc_pkg::STRM_ADDR_OFS: begin
                    s_next.rdata = {21'h0, s_reg.saddr};
                end
                bbsrc_pkg::MAP_OFS: begin
                    s_next.rdata = {26'h0, s_reg.map3, s_reg.map1,
                                    s_reg.route};
                end
                bbsrc_pkg::STATUS_OFS: begin
                    s_next.rdata = {s_reg.sptr, 4'h0, s_reg.lvl, s_reg.plen,
                                    s_reg.src, s_reg.pend, s_reg.ctrl.run};
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg          <= '0;
            s_reg.src      <= bbsrc_pkg::SRC_PRBS;
            s_reg.plen     <= bbsrc_pkg::prbs_len_9;
            s_reg.src_pend <= bbsrc_pkg::SRC_PRBS;
            s_reg.plen_pend <= bbsrc_pkg::prbs_len_9;
            s_reg.patlen   <= bbsrc_pkg::PAT_LEN_RST;
            s_reg.strm_len <= bbsrc_pkg::STRM_LEN_RST;
            s_reg.map1     <= 1'b1;
            s_reg.map3     <= 1'b1;
            s_reg.lfsr     <= 23'h0001ff;
            for (int i = 0; i < bbsrc_pkg::NUM_MARKERS; i++) begin
                s_reg.mcfg[i].on_len  <= bbsrc_pkg::MKR_CNT_RST;
                s_reg.mcfg[i].off_len <= bbsrc_pkg::MKR_CNT_RST;
                s_reg.mcfg[i].plen    <= bbsrc_pkg::PAT_LEN_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign rdata_out       = s_reg.rdata;
    assign sym_out         = s_reg.sym;
    assign sym_valid_out   = s_reg.sym_vld;
    assign clk_ext_sel_out = s_reg.ctrl.clk_ext;
    assign clk_out_en_out  = !s_reg.ctrl.clk_ext;

    // Connectors 1 and 3 double as other signals; 2 and 4 are markers only.
    for (genvar g = 0; g < 4; g++) begin : g_mkr
        assign marker_a_out[g] = s_reg.lvl[g] & !s_reg.route[g];
        assign marker_b_out[g] = s_reg.lvl[g] & s_reg.route[g];
        if (g == 0) begin : g_c1
            assign conn_out[g] = s_reg.map1 ? s_reg.lvl[g] : alt_in[0];
        end else if (g == 2) begin : g_c3
            assign conn_out[g] = s_reg.map3 ? s_reg.lvl[g] : alt_in[1];
        end else begin : g_cx
            assign conn_out[g] = s_reg.lvl[g];
        end
    end

endmodule : bb_data_source

// file: hdl/bbsrc_pkg.sv
package bbsrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses, one aligned word each).
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] SRC_OFS       = 8'h04;
    localparam logic [7:0] PAT_LO_OFS    = 8'h08;
    localparam logic [7:0] PAT_HI_OFS    = 8'h0c;
    localparam logic [7:0] PAT_LEN_OFS   = 8'h10;
    localparam logic [7:0] STRM_LEN_OFS  = 8'h14;
    localparam logic [7:0] STRM_ADDR_OFS = 8'h18;
    localparam logic [7:0] STRM_DATA_OFS = 8'h1c;
    localparam logic [7:0] RESTART_OFS   = 8'h20;
    localparam logic [7:0] MAP_OFS       = 8'h24;
    localparam logic [7:0] STATUS_OFS    = 8'h28;
    // Marker m occupies 8'h40 + 16*m: config, counts, pattern low, high.
    localparam logic [1:0] MKR_BLOCK     = 2'h1;
    localparam logic [1:0] MKR_CFG_IDX   = 2'h0;
    localparam logic [1:0] MKR_CNT_IDX   = 2'h1;
    localparam logic [1:0] MKR_PLO_IDX   = 2'h2;
    localparam logic [1:0] MKR_PHI_IDX   = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int          SRC_LEN_POS   = 4;
    localparam int          MAP_CONN1_POS = 4;
    localparam int          MAP_CONN3_POS = 5;
    localparam int          SYNC_STAGES   = 3;
    localparam int          NUM_MARKERS   = 4;
    localparam int          STRM_WORDS    = 2048;
    localparam int          BIT_DIV_RST   = 2;
    localparam logic [5:0]  PAT_LEN_RST   = 6'h3f;
    localparam logic [15:0] STRM_LEN_RST  = 16'hffff;
    localparam logic [15:0] MKR_CNT_RST   = 16'h0002;
    localparam logic [22:0] PRBS_ONES     = 23'h7fffff;

    ////////////////////////////////////////////////////////////////////////
    // Modes and selections.
    typedef enum logic [2:0] {
        SRC_PRBS, SRC_ZERO, SRC_ONE, SRC_PATTERN, SRC_STREAM
    } src_t;

    typedef enum logic [2:0] {
        prbs_len_9, prbs_len_11, prbs_len_15, prbs_len_16,
        prbs_len_20, prbs_len_21, prbs_len_23
    } prbs_len_t;

    typedef enum logic [1:0] {
        MK_RESTART, MK_PULSE, MK_PATTERN, MK_RATIO
    } mk_mode_t;

    // Stage count and feedback stages, indexed by prbs_len_t.
    localparam logic [4:0] PRBS_LEN [0:6] = '{
        5'd9, 5'd11, 5'd15, 5'd16, 5'd20, 5'd21, 5'd23
    };
    localparam logic [22:0] PRBS_TAPS [0:6] = '{
        23'h000011, 23'h000005, 23'h000003, 23'h00002d,
        23'h000009, 23'h000005, 23'h000021
    };

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic data_ext;
        logic trig_ext;
        logic clk_ext;
        logic qpsk;
        logic run;
    } ctrl_t;

    typedef struct packed {
        logic [63:0] pat;
        logic [15:0] off_len;
        logic [15:0] on_len;
        logic [5:0]  plen;
        mk_mode_t    mode;
    } mkr_cfg_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        ph;
        logic        first;
        logic [5:0]  idx;
    } mkr_st_t;

endpackage : bbsrc_pkg

// file: hdl/stream_mem.sv
module stream_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2048,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule : stream_mem

// file: dv/bb_src_assertions.sv
module bb_src_chk (
    input wire logic                clk_in,
    input wire logic                rst_in,
    input wire bbsrc_pkg::reg_req_t req_in,
    input wire logic [31:0]         rdata_out,
    input wire logic [1:0]          sym_out,
    input wire logic                sym_valid_out,
    input wire logic [3:0]          marker_a_out,
    input wire logic [3:0]          marker_b_out,
    input wire logic [3:0]          conn_out,
    input wire logic                clk_out_en_out,
    input wire logic                clk_ext_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_clk_sel_excl: assert property (
        clk_out_en_out != clk_ext_sel_out)
        else $error("clock drive and clock select agree");
    a_clk_sel_set: assert property (req_in.wr &&
        req_in.addr == bbsrc_pkg::CTRL_OFS |=> clk_ext_sel_out ==
        $past(req_in.wdata[2])) else $error("clock select not taken");
    a_clk_sel_cause: assert property ($changed(clk_ext_sel_out) |->
        $past(req_in.wr) && $past(req_in.addr) == bbsrc_pkg::CTRL_OFS)
        else $error("clock select moved without a write");
    a_route_excl: assert property (
        (marker_a_out & marker_b_out) == 4'h0)
        else $error("marker on both channels");
    a_conn_pair: assert property (conn_out[1] == |{marker_a_out[1],
        marker_b_out[1]} && conn_out[3] == |{marker_a_out[3],
        marker_b_out[3]}) else $error("fixed connector not a marker");
    a_valid_pulse: assert property (sym_valid_out |=> !sym_valid_out)
        else $error("symbol strobe too long");
    a_sym_hold: assert property ($changed(sym_out) |-> sym_valid_out)
        else $error("symbol moved without strobe");
    a_rdata_idle: assert property (
        !$past(req_in.rd) |-> rdata_out == 0)
        else $error("read data outside read slot");
endmodule : bb_src_chk

bind bb_data_source bb_src_chk u_chk (.clk_in, .rst_in, .req_in,
    .rdata_out, .sym_out, .sym_valid_out, .marker_a_out, .marker_b_out,
    .conn_out, .clk_out_en_out, .clk_ext_sel_out);

// file: dv/sym_sink.sv
module sym_sink (
    input wire logic       clk_in,
    input wire logic [1:0] sym_in,
    input wire logic       valid_in,
    input wire logic       mark_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each entry holds the marker level beside the symbol it flags.
    logic [2:0] q[$];
    always @(posedge clk_in) begin
        if (valid_in) q.push_back({mark_in, sym_in});
    end
endmodule : sym_sink

// file: dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_in = 1, trig_in = 0, data_in = 0;
    logic [1:0] alt_in = 2'b01, sym_out;
    logic [3:0] marker_a_out, marker_b_out, conn_out;
    logic [31:0] rdata_out, v;
    logic sym_valid_out, clk_out_en_out, clk_ext_sel_out;
    logic [22:0] s;
    bbsrc_pkg::reg_req_t req_in = '0;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    bb_data_source DUT (.clk_in, .rst_in, .req_in, .rdata_out, .trig_in,
        .data_in, .alt_in, .sym_out, .sym_valid_out, .marker_a_out,
        .marker_b_out, .conn_out, .clk_out_en_out, .clk_ext_sel_out);
    sym_sink rx (.clk_in, .sym_in(sym_out), .valid_in(sym_valid_out),
        .mark_in(marker_a_out[0]));
    initial forever #50 clk_in = ~clk_in;
    task complete_run;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // The limit sits well above the few thousand cycles the tests need.
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            complete_run();
        end
    end
    task chk(string n, logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in) req_in <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in) req_in <= '0;
        #1;
    endtask : wr
    task rd(logic [7:0] a);
        @(posedge clk_in) req_in <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_in) req_in <= '0;
        #1 v = rdata_out;
    endtask : rd
    task start(logic [31:0] src, logic [31:0] ctl);
        wr(bbsrc_pkg::CTRL_OFS, 0);
        wr(bbsrc_pkg::SRC_OFS, src);
        rx.q.delete();
        wr(bbsrc_pkg::CTRL_OFS, ctl);
    endtask : start
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 0;
        chk("clk_drive", clk_out_en_out, 1);
        rd(bbsrc_pkg::MAP_OFS);
        chk("map", v, 32'h30);
        rd(8'h44);
        chk("mark_cnt", v, 32'h00020002);
        rd(8'hfc);
        chk("unmapped", v, 0);
        wr(bbsrc_pkg::CTRL_OFS, 4);
        chk("clk_ext", {clk_ext_sel_out, clk_out_en_out}, 2'b10);
        $display("test registers done");
        for (int l = 0; l < 7; l++) begin
            start(l << bbsrc_pkg::SRC_LEN_POS, 1);
            wait (rx.q.size() >= 200);
            s = 23'((23'h1 << bbsrc_pkg::PRBS_LEN[l]) - 1);
            for (int i = 0; i < 200; i++) begin
                chk("prbs", rx.q[i][0],
                    s[0]);
                s = (s >> 1) | (23'(^(s & bbsrc_pkg::PRBS_TAPS[l]))
                    << (bbsrc_pkg::PRBS_LEN[l] - 1));
            end
        end
        $display("test prbs done");
        wr(bbsrc_pkg::PAT_LO_OFS, 32'h6);
        wr(bbsrc_pkg::PAT_LEN_OFS, 3);
        wr(8'h40, 3);
        wr(8'h44, {16'd3, 16'd2});
        start(3, 1);
        wait (rx.q.size() >= 10);
        for (int i = 0; i < 10; i++) begin
            chk("pattern", rx.q[i][0], (4'h6 >> (i % 4)) & 1);
            chk("ratio", rx.q[i][2], (i % 5) < 2);
        end
        wr(8'h40, 0);
        for (int k = 1; k < 3; k++) begin
            start(k, 3);
            wait (rx.q.size() >= 4);
            chk("qpsk", rx.q[3][1:0], {2{k == 2}});
            chk("mk_restart", {rx.q[0][2], rx.q[3][2]}, 2'b10);
        end
        $display("test pattern done");
        wr(bbsrc_pkg::STRM_DATA_OFS, 32'hc5);
        wr(bbsrc_pkg::STRM_LEN_OFS, 7);
        wr(8'h48, 32'h9);
        wr(8'h40, 32'he);
        start(4, 1);
        wait (rx.q.size() >= 10);
        for (int i = 0; i < 10; i++) begin
            chk("stream", rx.q[i][0], (8'hc5 >> (i % 8)) & 1);
            chk("mk_pattern", rx.q[i][2], (4'h9 >> (i % 4)) & 1);
        end
        $display("test stream done");
        wr(8'h40, 1);
        @(posedge clk_in) data_in <= 1;
        start(1, 32'h11);
        wait (rx.q.size() >= 4);
        for (int i = 0; i < 4; i++) begin
            chk("ext_data", rx.q[i][0], 1);
            chk("mk_pulse", rx.q[i][2], i % 2 == 0);
        end
        $display("test external done");
        wr(bbsrc_pkg::CTRL_OFS, 0);
        wr(bbsrc_pkg::MAP_OFS, 0);
        chk("conn", {conn_out[2], conn_out[0]}, 2'b01);
        $display("test mapping done");
        complete_run();
    end
endmodule : testbench
